// ===== design/timebase_regs.svh
// register indices, field masks and reset values for the time-base block
`ifndef TIMEBASE_REGS_SVH
`define TIMEBASE_REGS_SVH

// register indices; the byte address is four times the index
`define IDX_CTRL_ONE     8'h16
`define IDX_CTRL_TWO     8'h17
`define IDX_PERIOD_A     8'h20
`define IDX_PERIOD_B     8'h21
`define IDX_TIMER_A      8'h22
`define IDX_TIMER_B      8'h23
`define IDX_WIDE_LO      8'h24
`define IDX_WIDE_HI      8'h25
`define IDX_CAP_BASE     8'h26
`define IDX_CAP_LAST     8'h2D
`define IDX_CTRL_THREE   8'h2E
`define IDX_FLAGS        8'h2F

// writable fields and reset values
`define CTRL_TWO_WMASK   8'h3F
`define CTRL_THREE_WMASK 8'h1E
`define FLAGS_WMASK      8'h03
`define REG_RESET        8'h00
`define WIDE_RESET       16'h0000
`define WIDE_MAX         16'hFFFF
`define BYTE_MAX         8'hFF

// field positions inside the third control register and the flag register
`define CTRL_THREE_OVR_LSB  5
`define CTRL_THREE_MODE_LSB 1
`define FLAG_A_BIT          0
`define FLAG_B_BIT          1

`endif

// ===== design/timebase_pkg.sv
// types shared by the time-base block
`default_nettype none
package timebase_pkg;

  typedef enum logic [1:0] {
    CAP_FALL   = 2'b00,
    CAP_RISE   = 2'b01,
    CAP_RISE4  = 2'b10,
    CAP_RISE16 = 2'b11
  } cap_mode_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b01,
    PH_ACCESS = 2'b10
  } apb_phase_t;

  typedef struct packed {
    cap_mode_t capture_two_edge_mode;
    cap_mode_t capture_one_edge_mode;
    logic      cascade_select;
    logic      wide_timer_clock_source;
    logic      timer_b_clock_source;
    logic      timer_a_clock_source;
  } ctrl_one_t;

  typedef struct packed {
    logic capture_two_overrun;
    logic capture_one_overrun;
    logic pwm_channel_two_enable;
    logic pwm_channel_one_enable;
    logic period_or_capture_select;
    logic wide_timer_run;
    logic timer_b_run;
    logic timer_a_run;
  } ctrl_two_t;

endpackage : timebase_pkg
`default_nettype wire

// ===== design/timebase_ctrl.sv
// timers a/b, wide timer, four capture channels and pwm pin direction behind apb
//
// Design decision made here: the APB slave port.
`include "timebase_regs.svh"
`default_nettype none

// Overview of operation
// - two 8-bit up timers a and b, each with own period and flag
// - bit 0/1 pick shared external falling edges or internal clock for a/b
// - control-one bit 3 cascades b (high) and a (low) into 16 bits
// - control-one bit 2 picks wide-pin falling edges or internal clock for wide timer
// - control-two bit 3 makes extra pair capture one, else wide period
// - edge mode: falling, rising, every 4th rising, every 16th rising
// - capture two edge mode sits in control-one bits 7-6
// - capture one edge mode sits in control-one bits 5-4
// - every capture latches the wide timer count
// - capture while previous unread keeps the older value
// - after overrun capture stays frozen until both bytes are read
// - control-two bit 7 read-only, shows capture two overrun
// - control-two bit 6 read-only, shows capture one overrun
// - pwm two enable (bit 5) overrides port direction for its pin
// - pwm one enable (bit 4) overrides port direction for its pin
// - control-two bit 2 runs or stops the wide timer
// - timer a run bit gates the whole cascade, timer b run bit also its high byte; or timer a alone
// - counts of timers a and b are offered as pwm time bases
// - timers are shared freely, no user blocks another
// - 8-bit timer counts to period, then wraps to 00h and sets flag
// - cascade counts to 16-bit period, wraps to zero, sets flag a
// - in cascade timer a clock source governs both bytes
// - stopped timer neither counts nor sets its flag
module timebase_ctrl (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // apb slave
  input  wire logic       psel_i,
  input  wire logic       penable_i,
  input  wire logic       pwrite_i,
  input  wire logic [7:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0] pstrb_i,
  output logic            pready_o,
  output logic [31:0]     prdata_o,
  output logic            pslverr_o,
  // pins
  input  wire logic       shared_ext_clock_pin_i,
  input  wire logic       wide_ext_clock_pin_i,
  input  wire logic [3:0] capture_pin_i,
  input  wire logic [1:0] port_b_direction_i,
  output logic [1:0]      pwm_pin_oe_o,
  // time bases and flags
  output logic [7:0]      timer_a_count_o,
  output logic [7:0]      timer_b_count_o,
  output logic [15:0]     wide_timer_count_o,
  output logic            timer_a_int_flag_o,
  output logic            timer_b_int_flag_o
);

  function automatic logic cap_fire(input logic [1:0] mode, input logic rise,
                                    input logic fall, input logic [3:0] pre);
    case (mode)
      timebase_pkg::CAP_FALL:  cap_fire = fall;
      timebase_pkg::CAP_RISE:  cap_fire = rise;
      timebase_pkg::CAP_RISE4: cap_fire = rise & (pre[1:0] == 2'h3);
      default:                 cap_fire = rise & (pre == 4'hF);
    endcase
  endfunction : cap_fire

  function automatic logic [7:0] wbyte(input logic [7:0] old, input logic [7:0] mask);
    wbyte = (old & ~mask) | (pwdata_i[7:0] & mask);
  endfunction : wbyte

  timebase_pkg::ctrl_one_t  ctrl_one;
  timebase_pkg::ctrl_two_t  ctrl_two;
  timebase_pkg::apb_phase_t phase;
  logic [7:0]  ctrl_three;
  logic [7:0]  period_a;
  logic [7:0]  period_b;
  logic [15:0] cap_val [4];
  logic [3:0]  cap_full;
  logic [3:0]  cap_ovr;
  logic [3:0]  rd_lo;
  logic [3:0]  rd_hi;
  logic [3:0]  pre_cnt [4];
  logic [2:0]  sh_sync;
  logic [2:0]  wd_sync;
  logic [2:0]  cp_sync [4];
  logic [3:0]  cap_rise;
  logic [3:0]  cap_fall;
  logic [3:0]  cap_evt;
  logic [3:0]  cap_done;
  logic [1:0]  cap_mode [4];
  logic        access;
  logic        wr;
  logic        rd;
  logic [7:0]  idx;
  logic        idx_ok;
  logic        hit;
  logic [7:0]  next_rdata;
  logic [7:0]  wmask;
  logic        shared_fall;
  logic        wide_fall;
  logic        tick_a;
  logic        tick_b;
  logic        tick_w;
  logic        wrap_a;
  logic        wrap_b;
  logic        casc_match;
  logic [3:0]  ovr_nib;

  // apb decode
  assign access = psel_i & penable_i & pready_o;
  assign wr     = access & pwrite_i;
  assign rd     = access & ~pwrite_i;
  assign idx    = {2'b00, paddr_i[7:2]};
  assign idx_ok = (paddr_i[1:0] == 2'b00);
  assign wmask  = {8{pstrb_i[0]}};
  assign ovr_nib = cap_ovr;

  always_comb begin
    hit = idx_ok;
    next_rdata = `REG_RESET;
    case (idx)
      `IDX_CTRL_ONE:   next_rdata = ctrl_one;
      `IDX_CTRL_TWO:   next_rdata = {cap_ovr[1], cap_ovr[0], ctrl_two[5:0]};
      `IDX_PERIOD_A:   next_rdata = period_a;
      `IDX_PERIOD_B:   next_rdata = period_b;
      `IDX_TIMER_A:    next_rdata = timer_a_count_o;
      `IDX_TIMER_B:    next_rdata = timer_b_count_o;
      `IDX_WIDE_LO:    next_rdata = wide_timer_count_o[7:0];
      `IDX_WIDE_HI:    next_rdata = wide_timer_count_o[15:8];
      `IDX_CTRL_THREE: next_rdata = {1'b0, ovr_nib[3:2], ctrl_three[4:0]};
      `IDX_FLAGS:      next_rdata = {6'h00, timer_b_int_flag_o, timer_a_int_flag_o};
      default: begin
        if (idx >= `IDX_CAP_BASE && idx <= `IDX_CAP_LAST) begin
          next_rdata = idx[0] ? cap_val[idx[2:1] - 2'd3][15:8]
                              : cap_val[idx[2:1] - 2'd3][7:0];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  // apb handshake: one wait-free access phase after each setup
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase     <= timebase_pkg::PH_IDLE;
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      case (phase)
        timebase_pkg::PH_IDLE: begin
          if (psel_i && !penable_i) begin
            phase     <= timebase_pkg::PH_ACCESS;
            pready_o  <= 1'b1;
            pslverr_o <= ~hit;
            prdata_o  <= {24'h00_0000, (pwrite_i ? 8'h00 : next_rdata)};
          end
        end
        timebase_pkg::PH_ACCESS: begin
          phase     <= timebase_pkg::PH_IDLE;
          pready_o  <= 1'b0;
          pslverr_o <= 1'b0;
        end
        default: begin
          phase    <= timebase_pkg::PH_IDLE;
          pready_o <= 1'b0;
        end
      endcase
    end
  end

  // control and period registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_one   <= `REG_RESET;
      ctrl_two   <= `REG_RESET;
      ctrl_three <= `REG_RESET;
      period_a   <= `REG_RESET;
      period_b   <= `REG_RESET;
    end else if (wr && idx_ok) begin
      case (idx)
        `IDX_CTRL_ONE:   ctrl_one <= wbyte(ctrl_one, wmask);
        `IDX_CTRL_TWO:   ctrl_two <= wbyte(ctrl_two, wmask & `CTRL_TWO_WMASK);
        `IDX_CTRL_THREE: ctrl_three <= wbyte(ctrl_three, wmask & `CTRL_THREE_WMASK);
        `IDX_PERIOD_A:   period_a <= wbyte(period_a, wmask);
        `IDX_PERIOD_B:   period_b <= wbyte(period_b, wmask);
        default: begin
        end
      endcase
    end
  end

  // pin synchronisers and edge detection
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sh_sync <= 3'b111;
      wd_sync <= 3'b111;
      for (int i = 0; i < 4; i++) begin
        cp_sync[i] <= 3'b111;
      end
    end else begin
      sh_sync <= {sh_sync[1:0], shared_ext_clock_pin_i};
      wd_sync <= {wd_sync[1:0], wide_ext_clock_pin_i};
      for (int i = 0; i < 4; i++) begin
        cp_sync[i] <= {cp_sync[i][1:0], capture_pin_i[i]};
      end
    end
  end

  assign shared_fall = sh_sync[2] & ~sh_sync[1];
  assign wide_fall   = wd_sync[2] & ~wd_sync[1];
  assign tick_a = ctrl_one.timer_a_clock_source ? shared_fall : 1'b1;
  assign tick_b = ctrl_one.timer_b_clock_source ? shared_fall : 1'b1;
  assign tick_w = ctrl_one.wide_timer_clock_source ? wide_fall : 1'b1;
  assign casc_match = {timer_b_count_o, timer_a_count_o} == {period_b, period_a};
  assign wrap_a = ctrl_two.timer_a_run & tick_a &
                  (ctrl_one.cascade_select ? casc_match : timer_a_count_o == period_a);
  assign wrap_b = ~ctrl_one.cascade_select & ctrl_two.timer_b_run & tick_b &
                  (timer_b_count_o == period_b);

  // timers a and b, separate or cascaded
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_a_count_o <= `REG_RESET;
      timer_b_count_o <= `REG_RESET;
    end else begin
      if (ctrl_one.cascade_select) begin
        if (ctrl_two.timer_a_run && tick_a) begin
          if (casc_match) begin
            timer_a_count_o <= `REG_RESET;
            timer_b_count_o <= `REG_RESET;
          end else begin
            timer_a_count_o <= timer_a_count_o + 8'h01;
            if (ctrl_two.timer_b_run && timer_a_count_o == `BYTE_MAX) begin
              timer_b_count_o <= timer_b_count_o + 8'h01;
            end
          end
        end
      end else begin
        if (ctrl_two.timer_a_run && tick_a) begin
          timer_a_count_o <= wrap_a ? `REG_RESET : timer_a_count_o + 8'h01;
        end
        if (ctrl_two.timer_b_run && tick_b) begin
          timer_b_count_o <= wrap_b ? `REG_RESET : timer_b_count_o + 8'h01;
        end
      end
      if (wr && idx == `IDX_TIMER_A) begin
        timer_a_count_o <= wbyte(timer_a_count_o, wmask);
      end
      if (wr && idx == `IDX_TIMER_B) begin
        timer_b_count_o <= wbyte(timer_b_count_o, wmask);
      end
    end
  end

  // overflow flags, write one to clear, set wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_a_int_flag_o <= 1'b0;
      timer_b_int_flag_o <= 1'b0;
    end else begin
      timer_a_int_flag_o <= wrap_a | (timer_a_int_flag_o &
        ~(wr && idx == `IDX_FLAGS && pstrb_i[0] && pwdata_i[`FLAG_A_BIT]));
      timer_b_int_flag_o <= wrap_b | (timer_b_int_flag_o &
        ~(wr && idx == `IDX_FLAGS && pstrb_i[0] && pwdata_i[`FLAG_B_BIT]));
    end
  end

  // wide timer: period from pair or free running
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wide_timer_count_o <= `WIDE_RESET;
    end else begin
      if (ctrl_two.wide_timer_run && tick_w) begin
        if (!ctrl_two.period_or_capture_select && wide_timer_count_o == cap_val[0]) begin
          wide_timer_count_o <= `WIDE_RESET;
        end else begin
          wide_timer_count_o <= wide_timer_count_o + 16'h0001;
        end
      end
      if (wr && idx == `IDX_WIDE_LO && pstrb_i[0]) begin
        wide_timer_count_o[7:0] <= pwdata_i[7:0];
      end
      if (wr && idx == `IDX_WIDE_HI && pstrb_i[0]) begin
        wide_timer_count_o[15:8] <= pwdata_i[7:0];
      end
    end
  end

  // capture channels
  always_comb begin
    cap_mode[0] = ctrl_one.capture_one_edge_mode;
    cap_mode[1] = ctrl_one.capture_two_edge_mode;
    cap_mode[2] = ctrl_three[`CTRL_THREE_MODE_LSB +: 2];
    cap_mode[3] = ctrl_three[`CTRL_THREE_MODE_LSB + 2 +: 2];
    for (int i = 0; i < 4; i++) begin
      cap_rise[i] = cp_sync[i][1] & ~cp_sync[i][2];
      cap_fall[i] = cp_sync[i][2] & ~cp_sync[i][1];
      cap_evt[i]  = cap_fire(cap_mode[i], cap_rise[i], cap_fall[i], pre_cnt[i]);
      cap_done[i] = cap_full[i] &
        (rd_lo[i] | (rd && idx == `IDX_CAP_BASE + 8'(2 * i))) &
        (rd_hi[i] | (rd && idx == `IDX_CAP_BASE + 8'(2 * i + 1)));
    end
    cap_evt[0] = cap_evt[0] & ctrl_two.period_or_capture_select;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_full <= 4'h0;
      cap_ovr  <= 4'h0;
      rd_lo    <= 4'h0;
      rd_hi    <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        cap_val[i] <= `WIDE_RESET;
        pre_cnt[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cap_rise[i]) begin
          pre_cnt[i] <= pre_cnt[i] + 4'h1;
        end
        if (rd && idx == `IDX_CAP_BASE + 8'(2 * i)) begin
          rd_lo[i] <= 1'b1;
        end
        if (rd && idx == `IDX_CAP_BASE + 8'(2 * i + 1)) begin
          rd_hi[i] <= 1'b1;
        end
        if (cap_done[i]) begin
          cap_full[i] <= 1'b0;
          cap_ovr[i]  <= 1'b0;
          rd_lo[i]    <= 1'b0;
          rd_hi[i]    <= 1'b0;
        end
        if (cap_evt[i]) begin
          if (cap_full[i] && !cap_done[i]) begin
            cap_ovr[i] <= 1'b1;
          end else begin
            cap_val[i]  <= wide_timer_count_o;
            cap_full[i] <= 1'b1;
            rd_lo[i]    <= 1'b0;
            rd_hi[i]    <= 1'b0;
          end
        end
      end
      if (!ctrl_two.period_or_capture_select && wr && pstrb_i[0]) begin
        if (idx == `IDX_CAP_BASE) begin
          cap_val[0][7:0] <= pwdata_i[7:0];
        end
        if (idx == `IDX_CAP_BASE + 8'h01) begin
          cap_val[0][15:8] <= pwdata_i[7:0];
        end
      end
    end
  end

  // pwm pins: enable forces drive, else port direction (1 = input)
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwm_pin_oe_o <= 2'b00;
    end else begin
      pwm_pin_oe_o[0] <= ctrl_two.pwm_channel_one_enable | ~port_b_direction_i[0];
      pwm_pin_oe_o[1] <= ctrl_two.pwm_channel_two_enable | ~port_b_direction_i[1];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  apb_setup_ready_a: assert property ((psel_i && !penable_i && !pready_o) |=> pready_o)
    else $error("no ready after setup");
  timer_a_wrap_a: assert property ((!ctrl_one.cascade_select && ctrl_two.timer_a_run && tick_a
      && timer_a_count_o == period_a && !wr) |=> (timer_a_count_o == 8'h00 && timer_a_int_flag_o))
    else $error("timer a did not wrap at period");
  timer_stop_hold_a: assert property ((!ctrl_two.timer_a_run && !wr)
      |=> (timer_a_count_o == $past(timer_a_count_o)))
    else $error("stopped timer a moved");
  cascade_wrap_a: assert property ((ctrl_one.cascade_select && ctrl_two.timer_a_run && tick_a
      && casc_match && !wr) |=> ({timer_b_count_o, timer_a_count_o} == 16'h0000
      && timer_a_int_flag_o))
    else $error("cascade did not wrap");
  wide_free_wrap_a: assert property ((ctrl_two.period_or_capture_select && ctrl_two.wide_timer_run
      && tick_w && wide_timer_count_o == 16'hFFFF && !wr) |=> wide_timer_count_o == 16'h0000)
    else $error("wide timer did not wrap");
  capture_latch_a: assert property ((cap_evt[1] && !cap_full[1])
      |=> (cap_val[1] == $past(wide_timer_count_o) && cap_full[1]))
    else $error("capture two did not latch");
  capture_keep_a: assert property ((cap_evt[1] && cap_full[1] && !cap_done[1])
      |=> (cap_ovr[1] && $stable(cap_val[1])))
    else $error("overrun replaced old capture");
  overrun_clear_a: assert property ((cap_done[1] && !cap_evt[1]) |=> !cap_ovr[1])
    else $error("overrun not cleared by reads");
  pwm_override_a: assert property (ctrl_two.pwm_channel_one_enable |=> pwm_pin_oe_o[0])
    else $error("pwm one enable ignored");

endmodule : timebase_ctrl
`default_nettype wire

// ===== verif/pin_partner.sv
// pin-side model: external count clocks and capture inputs
`default_nettype none
module pin_partner (
  // clock
  input  wire logic  clk_i,
  // pins
  output logic       shared_ext_clock_pin_o,
  output logic       wide_ext_clock_pin_o,
  output logic [3:0] capture_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // pins idle high, so the first change is a falling edge
  initial begin
    shared_ext_clock_pin_o = 1'b1;
    wide_ext_clock_pin_o   = 1'b1;
    capture_pin_o          = 4'hF;
  end

  // pin 8 is the shared clock, 9 the wide clock, 0..3 the captures
  // each level is held seven cycles, longer than the two-flop synchroniser
  task automatic set_pin(input int pin, input logic lvl);
    @(posedge clk_i);
    if (pin == 8) begin
      shared_ext_clock_pin_o <= lvl;
    end else if (pin == 9) begin
      wide_ext_clock_pin_o <= lvl;
    end else begin
      capture_pin_o[pin] <= lvl;
    end
    repeat (6) @(posedge clk_i);
  endtask : set_pin

  task automatic pulse(input int pin, input int n);
    repeat (n) begin
      set_pin(pin, 1'b0);
      set_pin(pin, 1'b1);
    end
  endtask : pulse
endmodule : pin_partner
`default_nettype wire

// ===== verif/tb_timer_capture_timebase_control.sv
// self-checking bench for the timer, capture and pwm direction block
`include "timebase_regs.svh"
`default_nettype none
module tb_timer_capture_timebase_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i              = 1'b0;
  logic        resetn_i           = 1'b0;
  logic        psel_i             = 1'b0;
  logic        penable_i          = 1'b0;
  logic        pwrite_i           = 1'b0;
  logic [7:0]  paddr_i            = 8'h00;
  logic [31:0] pwdata_i           = 32'h00000000;
  logic [1:0]  port_b_direction_i = 2'b00;
  logic        pready_o;
  logic [31:0] prdata_o;
  logic        pslverr_o;
  logic        shared_ext_clock_pin_i;
  logic        wide_ext_clock_pin_i;
  logic [3:0]  capture_pin_i;
  logic [1:0]  pwm_pin_oe_o;
  logic [7:0]  timer_a_count_o;
  logic [7:0]  timer_b_count_o;
  logic [15:0] wide_timer_count_o;
  logic        timer_a_int_flag_o;
  logic        timer_b_int_flag_o;
  int          num_errors         = 0;
  int          comparisons        = 0;
  logic [31:0] seed               = 32'h00000009;
  logic [7:0]  ctrl_idx [4]       = '{`IDX_CTRL_ONE, `IDX_CTRL_TWO, `IDX_CTRL_THREE, `IDX_FLAGS};

  always #5 clk_i = ~clk_i;

  timebase_ctrl i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .shared_ext_clock_pin_i(shared_ext_clock_pin_i), .wide_ext_clock_pin_i(wide_ext_clock_pin_i),
    .capture_pin_i(capture_pin_i), .port_b_direction_i(port_b_direction_i),
    .pwm_pin_oe_o(pwm_pin_oe_o), .timer_a_count_o(timer_a_count_o),
    .timer_b_count_o(timer_b_count_o), .wide_timer_count_o(wide_timer_count_o),
    .timer_a_int_flag_o(timer_a_int_flag_o), .timer_b_int_flag_o(timer_b_int_flag_o)
  );

  pin_partner i_pins (
    .clk_i(clk_i), .shared_ext_clock_pin_o(shared_ext_clock_pin_i),
    .wide_ext_clock_pin_o(wide_ext_clock_pin_i), .capture_pin_o(capture_pin_i)
  );

  task automatic final_report();
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic stuck(input string msg);
    num_errors++;
    $display("wrong value at %0t: %s timed out", $time, msg);
    final_report();
  endtask : stuck

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic rnd(output logic [7:0] r);
    seed = xorshift(seed);
    r = seed[7:0];
  endtask : rnd

  function automatic logic [1:0] exp_oe(input logic [1:0] en, input logic [1:0] dir);
    return en | ~dir;
  endfunction : exp_oe

  // captures expected in 16 pulses, counted on the falling or the rising half
  function automatic int exp_caps(input int mode, input int rising);
    if (mode == 0) return rising ? 0 : 16;
    if (rising == 0) return 0;
    return mode == 1 ? 16 : (mode == 2 ? 4 : 1);
  endfunction : exp_caps

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    int n;
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= addr;
    pwdata_i <= {24'h000000, wd};
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (n == 20) stuck("apb");
    rd = prdata_o[7:0];
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    logic       e;
    apb(1'b1, {idx[5:0], 2'b00}, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    logic e;
    apb(1'b0, {idx[5:0], 2'b00}, 8'h00, d, e);
  endtask : rd

  task automatic rd_cap(input int ch, output logic [15:0] v);
    rd(`IDX_CAP_BASE + 8'(2 * ch), v[7:0]);
    rd(`IDX_CAP_BASE + 8'(2 * ch + 1), v[15:8]);
  endtask : rd_cap

  // stop everything but the capture select, load control one, periods, zero counts
  task automatic arm(input logic [7:0] c1, input logic [7:0] pa, input logic [7:0] pb);
    wr(`IDX_CTRL_TWO, 8'h08);
    wr(`IDX_CTRL_ONE, c1);
    wr(`IDX_PERIOD_A, pa);
    wr(`IDX_PERIOD_B, pb);
    wr(`IDX_TIMER_A, 8'h00);
    wr(`IDX_TIMER_B, 8'h00);
    wr(`IDX_FLAGS, 8'h03);
  endtask : arm

  // sel 0 timer a, 1 timer b, 2 cascade, 3 wide timer
  task automatic wait_wrap(input int sel, input logic [15:0] per);
    logic [15:0] cur;
    logic [15:0] prev;
    int          n;
    prev = 16'h0000;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk_i);
      cur = sel == 0 ? {8'h00, timer_a_count_o} : sel == 1 ? {8'h00, timer_b_count_o} :
            sel == 2 ? {timer_b_count_o, timer_a_count_o} : wide_timer_count_o;
      if (n > 0 && cur < prev) break;
      prev = cur;
    end
    if (n == 3000) stuck("wrap");
    chk(prev, per, "count before wrap");
    chk(cur, 16'h0000, "count after wrap");
    @(posedge clk_i);
    if (sel < 3) chk(sel == 1 ? timer_b_int_flag_o : timer_a_int_flag_o, 1'b1, "wrap flag");
  endtask : wait_wrap

  task automatic check_stop();
    logic [31:0] snap;
    @(posedge clk_i);
    snap = {timer_b_count_o, timer_a_count_o, wide_timer_count_o};
    repeat (40) @(posedge clk_i);
    chk(snap[31:16], {timer_b_count_o, timer_a_count_o}, "8-bit timers moved");
    chk(snap[15:0], wide_timer_count_o, "wide timer moved");
  endtask : check_stop

  initial begin
    logic [7:0]  r;
    logic [7:0]  en;
    logic [7:0]  dir;
    logic [15:0] v;
    logic [15:0] last;
    logic [15:0] w0;
    logic        err;
    int          lo_n;
    int          hi_n;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ctrl_idx[i], r);
      chk(r, 8'h00, "reset value");
    end
    rnd(r);
    wr(`IDX_CTRL_ONE, r);
    rd(`IDX_CTRL_ONE, en);
    chk(en, r, "control one readback");
    wr(`IDX_CTRL_TWO, 8'hFF);
    rd(`IDX_CTRL_TWO, en);
    chk(en, 8'h3F, "overrun bits written");
    apb(1'b0, 8'h40, 8'h00, r, err);
    chk({7'h00, err, r}, 16'h0100, "unmapped read");
    apb(1'b1, 8'h59, 8'hFF, r, err);
    chk(err, 1'b1, "misaligned write");
    // two 8-bit timers with random periods
    rnd(en);
    rnd(dir);
    arm(8'h00, 8'd8 + {2'b00, en[5:0]}, 8'd8 + {2'b00, dir[5:0]});
    wr(`IDX_CTRL_TWO, 8'h0B);
    wait_wrap(0, 8'd8 + {2'b00, en[5:0]});
    wait_wrap(1, 8'd8 + {2'b00, dir[5:0]});
    wr(`IDX_CTRL_TWO, 8'h08);
    wr(`IDX_FLAGS, 8'h03);
    check_stop();
    chk({timer_b_int_flag_o, timer_a_int_flag_o}, 2'b00, "flag while stopped");
    // cascade, timer b clock source set but ignored
    arm(8'h0A, 8'h03, 8'h01);
    wr(`IDX_CTRL_TWO, 8'h0B);
    wait_wrap(2, 16'h0103);
    wr(`IDX_CTRL_TWO, 8'h0A);
    check_stop();
    // external count clocks
    arm(8'h03, 8'hFF, 8'hFF);
    wr(`IDX_CTRL_TWO, 8'h0B);
    i_pins.pulse(8, 5);
    wr(`IDX_CTRL_TWO, 8'h08);
    rd(`IDX_TIMER_A, r);
    chk(r, 8'd5, "timer a pin count");
    rd(`IDX_TIMER_B, r);
    chk(r, 8'd5, "timer b pin count");
    wr(`IDX_WIDE_LO, 8'h00);
    wr(`IDX_WIDE_HI, 8'h00);
    wr(`IDX_CTRL_ONE, 8'h04);
    wr(`IDX_CTRL_TWO, 8'h0C);
    i_pins.pulse(9, 3);
    wr(`IDX_CTRL_TWO, 8'h08);
    rd(`IDX_WIDE_LO, r);
    chk(r, 8'd3, "wide pin count");
    // wide timer with period, then free running
    wr(`IDX_CTRL_ONE, 8'h00);
    wr(`IDX_WIDE_LO, 8'h00);
    wr(`IDX_CTRL_TWO, 8'h00);
    wr(`IDX_CAP_BASE, 8'h10);
    wr(`IDX_CAP_BASE + 8'h01, 8'h00);
    wr(`IDX_CTRL_TWO, 8'h04);
    wait_wrap(3, 16'h0010);
    wr(`IDX_CTRL_TWO, 8'h08);
    check_stop();
    wr(`IDX_WIDE_LO, 8'hF0);
    wr(`IDX_WIDE_HI, 8'hFF);
    wr(`IDX_CTRL_TWO, 8'h0C);
    wait_wrap(3, 16'hFFFF);
    // edge modes on capture channels one and two
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 4; m++) begin
        wr(`IDX_CTRL_ONE, 8'(m << (4 + 2 * ch)));
        rd_cap(ch, last);
        lo_n = 0;
        hi_n = 0;
        for (int k = 0; k < 16; k++) begin
          i_pins.set_pin(ch, 1'b0);
          rd_cap(ch, v);
          if (v !== last) lo_n++;
          last = v;
          i_pins.set_pin(ch, 1'b1);
          rd_cap(ch, v);
          if (v !== last) hi_n++;
          last = v;
        end
        chk(16'(lo_n), 16'(exp_caps(m, 0)), "captures on falls");
        chk(16'(hi_n), 16'(exp_caps(m, 1)), "captures on rises");
      end
    end
    // overrun keeps the older value until both bytes are read
    for (int ch = 0; ch < 2; ch++) begin
      wr(`IDX_CTRL_ONE, 8'(1 << (4 + 2 * ch)));
      rd_cap(ch, last);
      w0 = wide_timer_count_o;
      i_pins.pulse(ch, 1);
      rd_cap(ch, v);
      chk((v - w0) > 16'd4 && (v - w0) < 16'd40, 1'b1, "capture time base");
      i_pins.pulse(ch, 1);
      rd(`IDX_CAP_BASE + 8'(2 * ch), r);
      i_pins.pulse(ch, 1);
      rd(`IDX_CTRL_TWO, en);
      chk(en[6 + ch], 1'b1, "overrun set");
      rd(`IDX_CAP_BASE + 8'(2 * ch), dir);
      chk(dir, r, "older capture kept");
      rd(`IDX_CAP_BASE + 8'(2 * ch + 1), dir);
      rd(`IDX_CTRL_TWO, en);
      chk(en[6 + ch], 1'b0, "overrun cleared");
      rd_cap(ch, last);
      i_pins.pulse(ch, 1);
      rd_cap(ch, v);
      chk(v !== last, 1'b1, "capture resumes");
    end
    wr(`IDX_CTRL_THREE, 8'h0A);
    rd_cap(2, last);
    i_pins.pulse(2, 1);
    rd_cap(2, v);
    chk(v !== last, 1'b1, "capture three");
    // pwm pins: enable overrides the direction bit
    for (int i = 0; i < 8; i++) begin
      rnd(en);
      rnd(dir);
      wr(`IDX_CTRL_TWO, {2'b00, en[1:0], 4'hC});
      port_b_direction_i <= dir[1:0];
      repeat (3) @(posedge clk_i);
      chk(pwm_pin_oe_o, exp_oe(en[1:0], dir[1:0]), "pwm pin enable");
    end
    final_report();
  end
endmodule : tb_timer_capture_timebase_control
`default_nettype wire
